// ==== rtl/apbt_pkg.sv ====
package apbt_pkg;

	// ==========================================
	// widths
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int CNT_W  = 18;

	// ==========================================
	// timing figures (ns, us) and derived cycle counts at 250 MHz
	localparam int CLK_PERIOD_NS  = 4;
	localparam int T_RC_MIN_NS    = 80;
	localparam int T_AA_MAX_NS    = 70;
	localparam int T_ASO_MIN_NS   = 10;
	localparam int T_WHOL_MIN_NS  = 15;
	localparam int T_WC_MIN_NS    = 80;
	localparam int T_WP_MIN_NS    = 45;
	localparam int T_CP_MIN_NS    = 15;
	localparam int T_CSP_MIN_NS   = 10;
	localparam int T_C2LP_MIN_NS  = 80;
	localparam int T_CHH_MIN_US   = 300;
	localparam int T_CHX_MIN_NS   = 10;
	localparam int T_HZ_MAX_NS    = 20;
	localparam int T_RD_GUARD_NS  = 5;

	localparam int CY_ASO  = (T_ASO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CY_AA   = (T_AA_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CY_RC   = (T_RC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CY_WHOL = (T_WHOL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CY_WC   = (T_WC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CY_WP   = (T_WP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CY_CP   = (T_CP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CY_CSP  = (T_CSP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CY_C2LP = (T_C2LP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CY_CHX  = (T_CHX_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CY_HZ   = (T_HZ_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CY_CHH_DEF = T_CHH_MIN_US * 1000 / CLK_PERIOD_NS;

	// ==========================================
	// pin bundles
	typedef struct packed {
		logic              chipSelectN;
		logic              powerKeep;
		logic              writeStrobeN;
		logic              outStrobeN;
		logic              lowLaneN;
		logic              highLaneN;
		logic [ADDR_W-1:0] addr;
	} apbt_pins_s;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0]        laneEn;
	} apbt_req_s;

	localparam apbt_pins_s PINS_IDLE = '{chipSelectN: 1'b1, powerKeep: 1'b1,
		writeStrobeN: 1'b1, outStrobeN: 1'b1, lowLaneN: 1'b1, highLaneN: 1'b1,
		addr: '0};

	typedef enum logic [3:0] {
		ST_WAKE, ST_IDLE, ST_RD_SETUP, ST_RD_WAIT, ST_RD_END,
		ST_WR_PULSE, ST_WR_END, ST_DESEL, ST_PD_SETUP, ST_PD_HOLD, ST_PD
	} apbt_state_e;

endpackage

// ==== rtl/apbt_host.sv ====
`timescale 1ns/1ns
module apbt_host #(
	parameter int WAKE_CYCLES = apbt_pkg::CY_CHH_DEF
) (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	input  wire logic                        clkEn,
	// user request side
	input  wire logic                        reqValid,
	output logic                             reqReady,
	input  wire apbt_pkg::apbt_req_s         req,
	input  wire logic                        sleepReq,
	output logic                             rdValid,
	output logic [apbt_pkg::DATA_W-1:0]      rdData,
	output logic                             asleep,
	// memory pins
	output apbt_pkg::apbt_pins_s             pins,
	input  wire logic [apbt_pkg::DATA_W-1:0] dataPinsIn,
	output logic [apbt_pkg::DATA_W-1:0]      dataPinsOut,
	output logic                             dataPinsOe
);
	import apbt_pkg::*;

	// ==========================================
	// input synchroniser for the data pins
	logic [DATA_W-1:0] dinMeta_r, dinSync_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dinMeta_r <= '0;
			dinSync_r <= '0;
		end else if (clkEn) begin
			dinMeta_r <= dataPinsIn;
			dinSync_r <= dinMeta_r;
		end
	end

	// ==========================================
	// sequencer
	apbt_state_e       state_r, state_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;
	logic [CNT_W-1:0]  recov_r, recov_nxt;
	logic              lastWr_r, lastWr_nxt;
	apbt_pins_s        pins_r, pins_nxt;
	logic [DATA_W-1:0] wdata_r, wdata_nxt;
	logic              oe_r, oe_nxt;
	logic [DATA_W-1:0] rdData_r, rdData_nxt;
	logic              rdValid_r, rdValid_nxt;

	// sample point: access time plus two synchroniser stages
	localparam logic [CNT_W-1:0] RD_SAMPLE = CNT_W'(CY_AA + 2);
	localparam logic [CNT_W-1:0] RD_LEN    = CNT_W'(CY_RC > CY_AA + 2 ? CY_RC : CY_AA + 2);
	localparam logic [CNT_W-1:0] WR_PULSE  = CNT_W'(CY_WP);
	localparam logic [CNT_W-1:0] WR_REST   = CNT_W'(CY_WC - CY_WP);
	localparam logic [CNT_W-1:0] ASO_LEN   = CNT_W'(CY_ASO);
	localparam logic [CNT_W-1:0] WHOL_LEN  = CNT_W'(CY_WHOL);
	localparam logic [CNT_W-1:0] CHX_LEN   = CNT_W'(CY_CHX > CY_HZ ? CY_CHX : CY_HZ);
	localparam logic [CNT_W-1:0] CP_LEN    = CNT_W'(CY_CP);
	localparam logic [CNT_W-1:0] CSP_LEN   = CNT_W'(CY_CSP);
	localparam logic [CNT_W-1:0] C2LP_LEN  = CNT_W'(CY_C2LP);
	localparam logic [CNT_W-1:0] WAKE_LEN  = CNT_W'(WAKE_CYCLES);
	localparam logic [CNT_W-1:0] ONE       = CNT_W'(1);

	always_comb begin
		state_nxt   = state_r;
		cnt_nxt     = (cnt_r != '0) ? cnt_r - ONE : cnt_r;
		recov_nxt   = (recov_r != '0) ? recov_r - ONE : recov_r;
		lastWr_nxt  = lastWr_r;
		pins_nxt    = pins_r;
		wdata_nxt   = wdata_r;
		oe_nxt      = oe_r;
		rdData_nxt  = rdData_r;
		rdValid_nxt = 1'b0;
		case (state_r)
			ST_WAKE: begin
				pins_nxt = PINS_IDLE;
				if (cnt_r == '0) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				// select and output strobe stay high between accesses, so outputs stay disabled
				if (sleepReq && recov_r == '0) begin
					cnt_nxt   = CSP_LEN;
					state_nxt = ST_PD_SETUP;
				end else if (reqValid && recov_r == '0) begin
					pins_nxt.addr        = req.addr;
					pins_nxt.chipSelectN = 1'b0;
					pins_nxt.outStrobeN  = 1'b1;
					if (req.write) begin
						// lanes fall with the strobe, one common pulse
						pins_nxt.writeStrobeN = 1'b0;
						pins_nxt.lowLaneN     = ~req.laneEn[0];
						pins_nxt.highLaneN    = ~req.laneEn[1];
						wdata_nxt             = req.wdata;
						oe_nxt                = 1'b1;
						cnt_nxt               = WR_PULSE;
						state_nxt             = ST_WR_PULSE;
					end else begin
						pins_nxt.lowLaneN  = ~req.laneEn[0];
						pins_nxt.highLaneN = ~req.laneEn[1];
						// after a write, the turnaround gap covers the setup
						cnt_nxt   = (lastWr_r && WHOL_LEN > ASO_LEN) ? WHOL_LEN : ASO_LEN;
						state_nxt = ST_RD_SETUP;
					end
				end
			end
			ST_RD_SETUP: begin
				if (cnt_r == '0) begin
					pins_nxt.outStrobeN = 1'b0;
					cnt_nxt             = RD_LEN;
					state_nxt           = ST_RD_WAIT;
				end
			end
			ST_RD_WAIT: begin
				if (cnt_r == (RD_LEN - RD_SAMPLE)) begin
					rdData_nxt  = dinSync_r;
					rdValid_nxt = 1'b1;
				end
				if (cnt_r == '0) begin
					pins_nxt.chipSelectN = 1'b1;
					cnt_nxt              = CHX_LEN;
					lastWr_nxt           = 1'b0;
					state_nxt            = ST_RD_END;
				end
			end
			ST_WR_PULSE: begin
				if (cnt_r == '0) begin
					// select rises first; strobes held for standby entry
					pins_nxt.chipSelectN = 1'b1;
					cnt_nxt              = WR_REST;
					state_nxt            = ST_WR_END;
				end
			end
			ST_WR_END: begin
				if (cnt_r == '0 && CHX_LEN <= WR_REST - cnt_r) begin
					oe_nxt     = 1'b0;
					lastWr_nxt = 1'b1;
					state_nxt  = ST_DESEL;
				end
			end
			ST_RD_END: begin
				if (cnt_r == '0) begin
					state_nxt = ST_DESEL;
				end
			end
			ST_DESEL: begin
				// strobes and lanes released only now, select high long enough
				pins_nxt  = '{chipSelectN: 1'b1, powerKeep: 1'b1, writeStrobeN: 1'b1,
					outStrobeN: 1'b1, lowLaneN: 1'b1, highLaneN: 1'b1, addr: pins_r.addr};
				recov_nxt = CP_LEN;
				state_nxt = ST_IDLE;
			end
			ST_PD_SETUP: begin
				if (cnt_r == '0) begin
					pins_nxt.powerKeep = 1'b0;
					cnt_nxt            = C2LP_LEN;
					state_nxt          = ST_PD_HOLD;
				end
			end
			ST_PD_HOLD: begin
				if (cnt_r == '0) begin
					state_nxt = ST_PD;
				end
			end
			ST_PD: begin
				if (!sleepReq) begin
					pins_nxt.powerKeep = 1'b1;
					cnt_nxt            = WAKE_LEN;
					state_nxt          = ST_WAKE;
				end
			end
			default: begin
				state_nxt = ST_WAKE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r   <= ST_WAKE;
			cnt_r     <= WAKE_LEN;
			recov_r   <= '0;
			lastWr_r  <= 1'b0;
			pins_r    <= PINS_IDLE;
			wdata_r   <= '0;
			oe_r      <= 1'b0;
			rdData_r  <= '0;
			rdValid_r <= 1'b0;
		end else if (clkEn) begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			recov_r   <= recov_nxt;
			lastWr_r  <= lastWr_nxt;
			pins_r    <= pins_nxt;
			wdata_r   <= wdata_nxt;
			oe_r      <= oe_nxt;
			rdData_r  <= rdData_nxt;
			rdValid_r <= rdValid_nxt;
		end
	end

	// ==========================================
	// outputs
	assign reqReady    = (state_r == ST_IDLE) && !sleepReq && (recov_r == '0);
	assign rdValid     = rdValid_r;
	assign rdData      = rdData_r;
	assign asleep      = (state_r == ST_PD);
	assign pins        = pins_r;
	assign dataPinsOut = wdata_r;
	assign dataPinsOe  = oe_r;

endmodule

// ==== test/apbt_host_props.sv ====
`timescale 1ns/1ns
// ==========================================
// pin timing checks
module apbt_host_props #(
	parameter int WAKE_CYCLES = 20
) (
	// clock and reset
	input wire logic                 sys_clk,
	input wire logic                 rst,
	// memory side
	input wire apbt_pkg::apbt_pins_s pins,
	input wire logic                 dataPinsOe
);
	import apbt_pkg::*;
	logic [17:0] selCnt_r, selCnt_nxt, pkCnt_r, pkCnt_nxt, wake_r, wake_nxt;
	// plain counters: long minima exceed what repetition can unroll
	always_comb begin
		selCnt_nxt = pins.chipSelectN ? 18'h0 : selCnt_r + 18'h1;
		pkCnt_nxt  = pins.powerKeep ? 18'h0 : pkCnt_r + 18'h1;
		wake_nxt   = pins.powerKeep ? wake_r + 18'h1 : 18'h0;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			selCnt_r <= 18'h0;
			pkCnt_r  <= 18'h0;
			wake_r   <= 18'h0;
		end else begin
			selCnt_r <= selCnt_nxt;
			pkCnt_r  <= pkCnt_nxt;
			wake_r   <= wake_nxt;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_strobesHeld;
		($stable(pins.writeStrobeN) && $stable(pins.outStrobeN))[*3];
	endsequence
	a_read_cycle_len: assert property ($rose(pins.chipSelectN) && !pins.outStrobeN
		|-> selCnt_r >= CY_RC)
		else $error("read cycle short");
	a_write_pulse_len: assert property ($rose(pins.chipSelectN) && !pins.writeStrobeN
		|-> selCnt_r >= CY_WP)
		else $error("write pulse short");
	a_addr_setup: assert property ($fell(pins.outStrobeN)
		|-> pins.addr == $past(pins.addr, 3))
		else $error("address setup short");
	a_write_read_gap: assert property ($rose(pins.writeStrobeN) |-> pins.outStrobeN[*4])
		else $error("write to read gap short");
	a_no_read_write: assert property (!pins.writeStrobeN |-> pins.outStrobeN)
		else $error("output strobe low in write");
	a_standby_hold: assert property ($rose(pins.chipSelectN) |-> s_strobesHeld)
		else $error("strobes moved at deselect");
	a_sleep_hold: assert property ($rose(pins.powerKeep) |-> pkCnt_r >= CY_C2LP)
		else $error("power-down too short");
	a_wake_wait: assert property ($fell(pins.chipSelectN) |-> wake_r >= WAKE_CYCLES)
		else $error("access before wake wait");
	a_drive_dir: assert property (dataPinsOe |-> pins.outStrobeN && pins.powerKeep)
		else $error("host drives while read");
	a_lane_gap: assert property ($rose(pins.lowLaneN) |-> pins.lowLaneN[*4])
		else $error("lane high gap short");
	a_pd_standby: assert property ($fell(pins.powerKeep)
		|-> pins.chipSelectN && !dataPinsOe)
		else $error("power-down not from standby");
endmodule
bind apbt_host apbt_host_props #(.WAKE_CYCLES(WAKE_CYCLES)) u_props (.sys_clk(sys_clk),
	.rst(rst), .pins(pins), .dataPinsOe(dataPinsOe));

// ==== test/apbt_mem_model.sv ====
`timescale 1ns/1ns
// ==========================================
// behavioural memory, 256 words deep
module apbt_mem_model #(
	parameter int ACC_NS = 68
) (
	// host pins
	input wire apbt_pkg::apbt_pins_s pins,
	input wire logic [15:0]          hostData,
	input wire logic                 hostOe,
	// resolved data pins
	output wire logic [15:0]         bus
);
	import apbt_pkg::*;
	logic [15:0] mem [256];
	wire logic [15:0] word;
	wire logic sel  = pins.powerKeep & ~pins.chipSelectN;
	wire logic rdOn = sel & pins.writeStrobeN & ~pins.outStrobeN;
	wire logic wrOn = sel & ~pins.writeStrobeN;
	wire logic rdOnD;
	// slow on purpose: stale word until access time has run
	assign #ACC_NS word = mem[pins.addr[7:0]];
	assign #(40, 0) rdOnD = rdOn;
	// released bytes show the inverse, so a late sample cannot pass
	assign bus[7:0] = hostOe ? hostData[7:0] :
		(rdOnD & ~pins.lowLaneN) ? word[7:0] : ~word[7:0];
	assign bus[15:8] = hostOe ? hostData[15:8] :
		(rdOnD & ~pins.highLaneN) ? word[15:8] : ~word[15:8];
	always @(negedge wrOn) begin
		if (hostOe && !pins.lowLaneN) mem[pins.addr[7:0]][7:0] <= hostData[7:0];
		if (hostOe && !pins.highLaneN) mem[pins.addr[7:0]][15:8] <= hostData[15:8];
	end
endmodule

// ==== test/async_psram_bus_timing_bench.sv ====
`timescale 1ns/1ns
module async_psram_bus_timing_bench;
	import apbt_pkg::*;
	localparam int WAKE = 20;
	logic sys_clk, rst, clkEn, reqValid, reqReady, sleepReq, rdValid, asleep, dataPinsOe;
	logic [15:0] rdData, dataPinsIn, dataPinsOut;
	apbt_req_s req;
	apbt_pins_s pins;
	int miscompares, samples_checked;
	apbt_host #(.WAKE_CYCLES(WAKE)) uut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
		.reqValid(reqValid), .reqReady(reqReady), .req(req), .sleepReq(sleepReq),
		.rdValid(rdValid), .rdData(rdData), .asleep(asleep), .pins(pins),
		.dataPinsIn(dataPinsIn), .dataPinsOut(dataPinsOut), .dataPinsOe(dataPinsOe));
	apbt_mem_model mem (.pins(pins), .hostData(dataPinsOut), .hostOe(dataPinsOe),
		.bus(dataPinsIn));
	// ==========================================
	// shared tasks
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic go(input logic w, input logic [19:0] a, input logic [15:0] d,
		input logic [1:0] l);
		int n;
		// one idle edge, so back-to-back calls never re-raise valid at once
		@(negedge sys_clk);
		reqValid = 1'b1;
		req = '{w, a, d, l};
		n = 0;
		while (reqReady !== 1'b1 && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
		chk(n < 2000, 1'b1);
		@(negedge sys_clk);
		reqValid = 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, input logic [15:0] exp);
		int n;
		go(1'b0, a, 16'h0, 2'b11);
		n = 0;
		while (rdValid !== 1'b1 && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		chk(n < 100, 1'b1);
		chk(rdData, exp);
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset;
		chk(pins, PINS_IDLE);
		repeat (WAKE - 4) @(negedge sys_clk);
		chk({pins.chipSelectN, reqReady, dataPinsOe}, 3'b100);
		// wait runs out on the edge after the counter empties
		repeat (4) @(negedge sys_clk);
		chk(reqReady, 1'b0);
		repeat (2) @(negedge sys_clk);
		chk(reqReady, 1'b1);
		$display("reset test done");
	endtask
	task automatic t_freeze;
		apbt_pins_s held;
		go(1'b1, 20'h00077, 16'h5A5A, 2'b11);
		repeat (2) @(negedge sys_clk);
		held = pins;
		clkEn = 1'b0;
		repeat (10) @(negedge sys_clk);
		chk(pins, held);
		chk({pins.chipSelectN, pins.writeStrobeN, dataPinsOe}, 3'b001);
		clkEn = 1'b1;
		rd(20'h00077, 16'h5A5A);
		$display("freeze test done");
	endtask
	task automatic t_lanes;
		logic [15:0] exp;
		logic [15:0] d;
		go(1'b1, 20'h12345, 16'h0F0F, 2'b11);
		exp = 16'h0F0F;
		// each byte mask, read back straight after the write
		for (int i = 1; i < 4; i++) begin
			d = 16'(i * 16'h1111);
			go(1'b1, 20'h12345, d, i[1:0]);
			if (i[0]) exp[7:0] = d[7:0];
			if (i[1]) exp[15:8] = d[15:8];
			rd(20'h12345, exp);
		end
		go(1'b1, 20'h00001, 16'hC3A5, 2'b11);
		rd(20'h00001, 16'hC3A5);
		rd(20'h12345, 16'h3333);
		$display("lanes test done");
	endtask
	task automatic t_sleep;
		int n;
		sleepReq = 1'b1;
		n = 0;
		while (asleep !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		chk({asleep, pins.powerKeep, pins.chipSelectN, reqReady}, 4'hA);
		repeat (30) @(negedge sys_clk);
		chk(pins.powerKeep, 1'b0);
		sleepReq = 1'b0;
		repeat (WAKE - 4) @(negedge sys_clk);
		chk({pins.chipSelectN, reqReady}, 2'b10);
		go(1'b1, 20'hFFFFF, 16'hBEEF, 2'b11);
		rd(20'hFFFFF, 16'hBEEF);
		$display("sleep test done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		miscompares = 0;
		samples_checked = 0;
		{rst, clkEn, reqValid, sleepReq} = 4'hC;
		req = '0;
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		t_reset;
		t_lanes;
		t_freeze;
		t_sleep;
		results;
	end
	// whole run needs well under 2000 cycles
	initial begin
		#200000;
		miscompares++;
		results;
	end
endmodule
